//--- src/ict_pkg.sv
// Package for the instruction cycle timing sequencer
package ict_pkg;

	// Clock states per machine cycle
	localparam int unsigned STATES_PER_CYCLE = 4;
	// Machine-cycle count width (counts up to nine)
	localparam int unsigned MC_W = 4;
	localparam logic [MC_W-1:0] MC_ONE   = 4'h1;
	localparam logic [MC_W-1:0] MC_TWO   = 4'h2;
	localparam logic [MC_W-1:0] MC_THREE = 4'h3;
	localparam logic [MC_W-1:0] MC_FOUR  = 4'h4;
	localparam logic [MC_W-1:0] MC_FIVE  = 4'h5;
	localparam logic [MC_W-1:0] MC_NINE  = 4'h9;
	// Stretch field: added machine cycles beyond two, 0..7
	localparam int unsigned STRETCH_W = 3;
	localparam logic [STRETCH_W-1:0] STRETCH_RST = 3'h0;
	// Opcodes of interest
	localparam logic [7:0] OP_XOR_DIR_IMM = 8'h63;
	localparam logic [7:0] OP_XMOVE_RD_DP = 8'hE0;
	localparam logic [7:0] OP_XMOVE_RD_R0 = 8'hE2;
	localparam logic [7:0] OP_XMOVE_RD_R1 = 8'hE3;
	localparam logic [7:0] OP_XMOVE_WR_DP = 8'hF0;
	localparam logic [7:0] OP_XMOVE_WR_R0 = 8'hF2;
	localparam logic [7:0] OP_XMOVE_WR_R1 = 8'hF3;

	// Clock state within a machine cycle
	typedef enum logic [1:0] {
		state_one,
		state_two,
		state_three,
		state_four
	} ict_state_type;

	// Timing class of an opcode
	typedef struct packed {
		logic [MC_W-1:0] cycles;      // Machine cycles
		logic            ext_move;    // External data move
		logic            ext_write;   // Move is a write
	} ict_class_type;

	// Strobe outputs towards external data memory
	typedef struct packed {
		logic rd_n;
		logic wr_n;
	} ict_strobe_type;

endpackage : ict_pkg

//--- src/ict_sequencer.sv
// Instruction cycle timing sequencer: clock states, machine cycles, strobes
`timescale 1ns/1ps
module ict_sequencer
	import ict_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire logic [7:0]           opcode,
	input  wire logic                 opcode_valid,
	input  wire logic [STRETCH_W-1:0] stretch_cfg,
	output ict_state_type             clk_state,
	output logic                      fetch_strobe,
	output logic                      instr_start,
	output logic                      instr_done,
	output logic [MC_W-1:0]           mc_count,
	output logic [MC_W-1:0]           instr_cycles,
	output logic                      late_phase,
	output ict_strobe_type            ext_strobe
);

	// Class decode, shared by length lookup and move detection
	function automatic ict_class_type classify(input logic [7:0] op);
		ict_class_type c;
		c = '{cycles: MC_ONE, ext_move: 1'b0, ext_write: 1'b0};
		unique case (op)
			OP_XMOVE_RD_DP, OP_XMOVE_RD_R0, OP_XMOVE_RD_R1: begin
				c = '{cycles: MC_TWO, ext_move: 1'b1, ext_write: 1'b0};
			end
			OP_XMOVE_WR_DP, OP_XMOVE_WR_R0, OP_XMOVE_WR_R1: begin
				c = '{cycles: MC_TWO, ext_move: 1'b1, ext_write: 1'b1};
			end
			OP_XOR_DIR_IMM: c.cycles = MC_THREE;
			8'h22, 8'h32, 8'h83, 8'h93: c.cycles = MC_TWO;
			8'h80, 8'h43, 8'h53, 8'h75, 8'h85, 8'h90: c.cycles = MC_THREE;
			8'h02, 8'h12, 8'h10, 8'h20, 8'h30: c.cycles = MC_FOUR;
			8'hA4, 8'h84: c.cycles = MC_FIVE;
			8'h45, 8'h44, 8'h42, 8'h72, 8'hA0, 8'hA2, 8'h92, 8'hC0, 8'hD0,
			8'hD2, 8'h95, 8'h94, 8'hC5, 8'h65, 8'h64, 8'h62: c.cycles = MC_TWO;
			default: c.cycles = MC_ONE;
		endcase
		return c;
	endfunction : classify

	ict_state_type   state_reg;
	ict_class_type   cls_reg;
	logic [MC_W-1:0] mc_reg;
	logic [MC_W-1:0] len_reg;
	logic            busy_reg;
	logic            rd_reg;
	logic            wr_reg;
	logic            pos_tog_reg;
	logic            neg_tog_reg;
	logic            start;
	ict_class_type   cls_next;
	logic [MC_W-1:0] len_next;

	// A new instruction is taken at the end of the last cycle's state four or when idle
	assign start = opcode_valid && (!busy_reg || (state_reg == state_four && mc_reg == len_reg));
	assign cls_next = classify(opcode);
	assign len_next = cls_next.ext_move ? MC_TWO + MC_W'(stretch_cfg) : cls_next.cycles;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= state_one;
		end else if (start) begin
			state_reg <= state_one;
		end else begin
			unique case (state_reg)
				state_one:   state_reg <= state_two;
				state_two:   state_reg <= state_three;
				state_three: state_reg <= state_four;
				state_four:  state_reg <= state_one;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mc_reg   <= MC_ONE;
			len_reg  <= MC_ONE;
			busy_reg <= 1'b0;
			cls_reg  <= '0;
		end else if (start) begin
			mc_reg   <= MC_ONE;
			len_reg  <= len_next;
			busy_reg <= 1'b1;
			cls_reg  <= cls_next;
		end else if (busy_reg && state_reg == state_four) begin
			if (mc_reg == len_reg) begin
				busy_reg <= 1'b0;
			end else begin
				mc_reg <= mc_reg + MC_ONE;
			end
		end
	end

	// strobe spans all but first cycle
	// Strobe covers cycles two..last so its width scales with stretch
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
		end else if (start || !busy_reg) begin
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
		end else if (cls_reg.ext_move && state_reg == state_four) begin
			rd_reg <= !cls_reg.ext_write && mc_reg != len_reg;
			wr_reg <= cls_reg.ext_write && mc_reg != len_reg;
		end
	end

	// rising-edge toggle
	// Toggle pair avoids gating a flop with the clock itself
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pos_tog_reg <= 1'b0;
		end else begin
			pos_tog_reg <= !pos_tog_reg;
		end
	end

	// falling-edge copy
	// Needs near 50% duty cycle; copy catches up in the low half of each state
	always_ff @(negedge core_clk) begin
		if (sys_rst) begin
			neg_tog_reg <= 1'b0;
		end else begin
			neg_tog_reg <= pos_tog_reg;
		end
	end

	// Outputs
	assign clk_state    = state_reg;
	assign fetch_strobe = busy_reg && state_reg == state_one && mc_reg <= len_reg
		&& !cls_reg.ext_move ? 1'b1 : (busy_reg && state_reg == state_one && mc_reg == MC_ONE);
	assign instr_start  = start;
	assign instr_done   = busy_reg && state_reg == state_four && mc_reg == len_reg;
	assign mc_count     = mc_reg;
	assign instr_cycles = len_reg;
	// Pair differs only between a rising edge and the next falling edge
	assign late_phase   = !(pos_tog_reg ^ neg_tog_reg);
	assign ext_strobe   = '{rd_n: !rd_reg, wr_n: !wr_reg};

	// Assertions
	sequence s_cycle;
		clk_state == state_one ##1 clk_state == state_two ##1 clk_state == state_three
			##1 clk_state == state_four;
	endsequence

	property p_state_order;
		@(posedge core_clk) disable iff (sys_rst)
		(clk_state == state_one && !instr_start) |-> ##1 clk_state == state_two;
	endproperty
	a_state_order: assert property (p_state_order) else $error("state order broken");

	property p_four_states;
		@(posedge core_clk) disable iff (sys_rst)
		(busy_reg && clk_state == state_four && !instr_done) |=> s_cycle;
	endproperty
	a_four_states: assert property (p_four_states) else $error("cycle not four states");

	property p_restart;
		@(posedge core_clk) disable iff (sys_rst)
		instr_start |=> clk_state == state_one && mc_count == MC_ONE;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart at start");

	property p_single;
		@(posedge core_clk) disable iff (sys_rst)
		instr_start && classify(opcode).cycles == MC_ONE && !classify(opcode).ext_move
			|=> ##3 instr_done;
	endproperty
	a_single: assert property (p_single) else $error("single cycle not four clocks");

	property p_xor_len;
		@(posedge core_clk) disable iff (sys_rst)
		instr_start && opcode == OP_XOR_DIR_IMM |=> instr_cycles == MC_THREE;
	endproperty
	a_xor_len: assert property (p_xor_len) else $error("xor length wrong");

	property p_move_len;
		@(posedge core_clk) disable iff (sys_rst)
		instr_start && classify(opcode).ext_move
			|=> instr_cycles == MC_TWO + MC_W'($past(stretch_cfg));
	endproperty
	a_move_len: assert property (p_move_len) else $error("move length wrong");

	property p_len_range;
		@(posedge core_clk) disable iff (sys_rst)
		busy_reg |-> instr_cycles >= MC_ONE && instr_cycles <= MC_NINE;
	endproperty
	a_len_range: assert property (p_len_range) else $error("length out of range");

	property p_strobe_move;
		@(posedge core_clk) disable iff (sys_rst)
		!ext_strobe.rd_n || !ext_strobe.wr_n |-> busy_reg && cls_reg.ext_move
			&& mc_count >= MC_TWO;
	endproperty
	a_strobe_move: assert property (p_strobe_move) else $error("strobe outside move");

	property p_one_fetch;
		@(posedge core_clk) disable iff (sys_rst)
		fetch_strobe |=> (!fetch_strobe) [*3];
	endproperty
	a_one_fetch: assert property (p_one_fetch) else $error("two fetches in a cycle");

endmodule : ict_sequencer

//--- verification/ict_ext_mem.sv
// External data memory model that measures strobe widths
`timescale 1ns/1ps
module ict_ext_mem
	import ict_pkg::*;
(
	input  wire logic           core_clk,
	input  wire ict_strobe_type ext_strobe,
	output logic [5:0]          rd_width,
	output logic [5:0]          wr_width
);
	ict_strobe_type prev_reg;

	// strobe width count
	// Restarts on each falling strobe, so one width per access
	always_ff @(posedge core_clk) begin
		prev_reg <= ext_strobe;
		if (ext_strobe.rd_n === 1'b0)
			rd_width <= (prev_reg.rd_n === 1'b1) ? 6'h01 : rd_width + 6'h01;
		if (ext_strobe.wr_n === 1'b0)
			wr_width <= (prev_reg.wr_n === 1'b1) ? 6'h01 : wr_width + 6'h01;
	end
endmodule : ict_ext_mem

//--- verification/tb_top.sv
// Self-checking bench for the instruction cycle timing sequencer
`timescale 1ns/1ps
module tb_top
	import ict_pkg::*;
;
	logic                 core_clk;
	logic                 sys_rst;
	logic [7:0]           opcode;
	logic                 opcode_valid;
	logic [STRETCH_W-1:0] stretch_cfg;
	ict_state_type        clk_state;
	logic                 fetch_strobe;
	logic                 instr_start;
	logic                 instr_done;
	logic [MC_W-1:0]      mc_count;
	logic [MC_W-1:0]      instr_cycles;
	logic                 late_phase;
	ict_strobe_type       ext_strobe;
	logic [5:0]           rd_width;
	logic [5:0]           wr_width;
	int                   miscompares = 0;
	int                   n_tests = 0;
	logic [7:0]           moves [6] = '{8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};

	ict_sequencer ict_sequencer_i (.core_clk(core_clk), .sys_rst(sys_rst), .opcode(opcode),
		.opcode_valid(opcode_valid), .stretch_cfg(stretch_cfg), .clk_state(clk_state),
		.fetch_strobe(fetch_strobe), .instr_start(instr_start), .instr_done(instr_done),
		.mc_count(mc_count), .instr_cycles(instr_cycles), .late_phase(late_phase),
		.ext_strobe(ext_strobe));
	ict_ext_mem ict_ext_mem_i (.core_clk(core_clk), .ext_strobe(ext_strobe),
		.rd_width(rd_width), .wr_width(wr_width));

	// Free-running core clock, 25 ns period
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task cmp(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	task results;
		if (miscompares == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	// Runs one instruction; entered and left just after an edge, so calls may chain
	task run_op(input logic [7:0] op, input logic [2:0] st, input int n, input logic mv);
		int k;
		int f;
		k = 0;
		f = 0;
		opcode = op;
		stretch_cfg = st;
		opcode_valid = 1'b1;
		#1 cmp(8'(instr_start), 8'h01);
		while (k < 48 && !(k > 0 && instr_done === 1'b1)) begin
			@(posedge core_clk);
			#1;
			if (k == 0)
				opcode_valid = 1'b0;
			k++;
			cmp(8'(clk_state), 8'((k - 1) % 4));
			cmp(8'(ext_strobe), !mv || k < 5 ? 8'h03 : (op[4] ? 8'h02 : 8'h01));
			if (clk_state == state_one)
				f += 32'(fetch_strobe === 1'b1);
		end
		cmp(8'(k), 8'(4 * n));
		cmp(8'(mc_count), 8'(n));
		cmp(8'(instr_cycles), 8'(n));
		cmp(8'(f), mv ? 8'h01 : 8'(n));
		// Strobe ends on the edge after the last state four, so the width is whole then
		if (mv) begin
			@(posedge core_clk);
			#1 cmp(8'(op[4] ? wr_width : rd_width), 8'(4 * (n - 1)));
		end
	endtask : run_op

	task idle_and_phase;
		cmp(8'(mc_count), 8'h01);
		cmp(8'(instr_cycles), 8'h01);
		cmp(8'(ext_strobe), 8'h03);
		@(negedge core_clk);
		#1 cmp(8'(late_phase), 8'h01);
		@(posedge core_clk);
		#1 cmp(8'(late_phase), 8'h00);
	endtask : idle_and_phase

	// Main sequence: reset, then single, chained and stretched instructions
	initial begin
		sys_rst = 1'b1;
		opcode = 8'h00;
		opcode_valid = 1'b0;
		stretch_cfg = STRETCH_RST;
		repeat (5) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		idle_and_phase();
		run_op(8'hC8, 3'h0, 1, 1'b0);
		run_op(8'h95, 3'h0, 2, 1'b0);
		run_op(OP_XOR_DIR_IMM, 3'h0, 3, 1'b0);
		@(posedge core_clk);
		#1;
		for (int i = 0; i < 6; i++)
			run_op(moves[i], 3'(i), i + 2, 1'b1);
		run_op(OP_XMOVE_WR_R1, 3'h7, 9, 1'b1);
		results();
	end

	// Watchdog well beyond the roughly 180 cycles the tests need
	initial begin
		repeat (3000) @(posedge core_clk);
		miscompares++;
		results();
	end
endmodule : tb_top
